// File: core/sme_pkg.sv
// Purpose: shared constants and helpers for the eeprom access link
// Assumes: 200 MHz system clock, smbus at 100 kHz
// Notes: byte positions count from the byte after the slave address
package sme_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SMB_PERIOD_NS = 10000;
  // quarter of an smbus bit time, rounded down
  localparam int QUARTER_CYC = (SMB_PERIOD_NS * 1000) / CLK_PERIOD_PS / 4;
  localparam int GAP_CYC = 4000;
  localparam logic [6:0] SLAVE_ADDR = 7'h5a;
  // field positions of the write part of an exchange
  localparam logic [2:0] POS_CODE = 3'h0;
  localparam logic [2:0] POS_COUNT = 3'h1;
  localparam logic [2:0] POS_CTRL = 3'h2;
  localparam logic [2:0] POS_EEPROM_BUS_ADDRESS = 3'h3;
  localparam logic [2:0] POS_OFFL = 3'h4;
  localparam logic [2:0] POS_OFFH = 3'h5;
  localparam logic [2:0] POS_DATA = 3'h6;
  localparam logic [2:0] POS_LAST = 3'h7;
  // slave command code: function field and block flag
  localparam logic [2:0] CODE_FUNC_EEPROM = 3'h2;
  localparam int CODE_BLOCK_BIT = 3;
  localparam logic [7:0] COUNT_WRITE = 8'h05;
  localparam logic [7:0] COUNT_SETUP = 8'h04;
  localparam logic [7:0] COUNT_RETURN = 8'h02;
  // controller registers, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OFFSET = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_IRQ_ST = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    SYM_START, SYM_WR, SYM_RD_ACK, SYM_RD_NACK, SYM_STOP, SYM_SKIP,
    SYM_WAIT, SYM_END
  } sme_sym_type;

  // control byte: op bit0, use address bit1, errors bits 5:3
  function automatic logic [7:0] sme_ctrl_byte(input logic op,
    input logic use_given_address, input logic [2:0] err);
    sme_ctrl_byte = {2'b00, err, 1'b0, use_given_address, op};
  endfunction

  // byte-lane merge of a bus write
  function automatic logic [31:0] sme_merge(input logic [31:0] old,
    input logic [31:0] wr, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = sel[i] ? wr[8*i +: 8] : old[8*i +: 8];
    end
    sme_merge = old;
  endfunction
endpackage

// File: core/sme_link_if.sv
// Purpose: open-drain smbus wires between controller and device
// Assumes: each end pulls a wire low while its enable is low
// Notes: the wire level is resolved here, never in the ends
`timescale 1ns/1ps
interface sme_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl_i;
  logic sda_i;

  // wired-and with pull-up
  assign scl_i = ~((~host_scl_oe_n & ~host_scl_o) |
                   (~dev_scl_oe_n & ~dev_scl_o));
  assign sda_i = ~((~host_sda_oe_n & ~host_sda_o) |
                   (~dev_sda_oe_n & ~dev_sda_o));

  modport host (output host_scl_o, output host_scl_oe_n,
    output host_sda_o, output host_sda_oe_n, input sda_i);
  modport dev (output dev_scl_o, output dev_scl_oe_n,
    output dev_sda_o, output dev_sda_oe_n, input scl_i, input sda_i);
endinterface

// File: core/sme_dev.sv
// Purpose: slave smbus decoder for eeprom read and write commands
// Assumes: a master smbus engine does the eeprom access on request
// Notes: no clock stretching; busy ignores new writes to the fields after the code byte
`timescale 1ns/1ps
module sme_dev
  import sme_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sme_link_if.dev link,
  output logic ee_req,
  output logic ee_read,
  output logic [6:0] ee_bus_address,
  output logic [15:0] ee_offset,
  output logic [7:0] ee_wdata,
  input wire logic ee_done,
  input wire logic [7:0] ee_rdata,
  input wire logic ee_nack_err,
  input wire logic ee_arb_err,
  input wire logic ee_framing_err,
  input wire logic [6:0] default_master_address
);
  import sme_pkg::*;

  typedef enum logic [2:0] {
    PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_ACKIN, PH_WAIT
  } sme_phase_type;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    sme_phase_type ph;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic addr_byte;
    logic rd_xfer;
    logic [2:0] pos;
    logic [2:0] txi;
    logic block;
    logic code_ok;
    logic op;
    logic use_given_address;
    logic [7:0] eeprom_bus_address;
    logic [15:0] offset;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] flags;
    logic armed;
    logic busy;
    logic req;
    logic [6:0] bus_addr;
    logic sda_rel;
  } sme_dev_state_type;

  sme_dev_state_type s;
  sme_dev_state_type next_s;

  // logical field of a received byte; word forms lack the count byte
  function automatic logic [2:0] field_of(input logic [2:0] pos,
    input logic block);
    if (block || pos == POS_CODE) begin
      field_of = pos;
    end else begin
      field_of = pos + 3'h1;
    end
  endfunction

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic [2:0] rx_fld;
  logic [2:0] tx_fld;
  logic [7:0] tx_byte;

  assign scl = s.scl_sync[1];
  assign sda = s.sda_sync[1];
  assign scl_rise = scl & ~s.scl_q;
  assign scl_fall = ~scl & s.scl_q;
  assign rx_fld = field_of(s.pos, s.block);
  // response side: word forms drop the count, so status comes first
  assign tx_fld = s.block ? s.txi : s.txi + 3'h1;

  // response bytes: count, status, data
  always_comb begin
    case (tx_fld)
      POS_CODE: tx_byte = COUNT_RETURN;
      POS_COUNT: tx_byte = sme_ctrl_byte(s.op, s.use_given_address, s.flags);
      POS_CTRL: tx_byte = s.rdata;
      default: tx_byte = 8'hff;
    endcase
  end

  // one state copy: link decode, field capture, engine handshake
  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], link.scl_i};
    next_s.sda_sync = {s.sda_sync[0], link.sda_i};
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    next_s.req = 1'b0;
    // engine completion; read data kept for the returning read
    if (ee_done && s.busy) begin
      next_s.busy = 1'b0;
      if (s.op) begin
        next_s.rdata = ee_rdata;
      end
    end
    if (scl && s.scl_q && !sda && s.sda_q) begin
      // start or repeated start: a new address byte follows
      next_s.ph = PH_RX;
      next_s.addr_byte = 1'b1;
      next_s.bitcnt = 4'h0;
      next_s.pos = POS_CODE;
      next_s.txi = 3'h0;
      next_s.sda_rel = 1'b1;
    end else if (scl && s.scl_q && sda && !s.sda_q) begin
      // stop: launch the access once all fields have arrived
      if (s.armed && !s.busy) begin
        next_s.req = 1'b1;
        next_s.busy = 1'b1;
        next_s.bus_addr = s.use_given_address ? s.eeprom_bus_address[7:1] : default_master_address;
      end
      next_s.armed = 1'b0;
      next_s.ph = PH_IDLE;
      next_s.sda_rel = 1'b1;
    end else begin
      case (s.ph)
        PH_RX: begin
          if (scl_rise && s.bitcnt < 4'h8) begin
            next_s.sh = {s.sh[6:0], sda};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == 4'h8) begin
            next_s.ph = PH_ACK;
            next_s.sda_rel = 1'b0;
            if (s.addr_byte) begin
              next_s.rd_xfer = s.sh[0];
              if (s.sh[7:1] != SLAVE_ADDR) begin
                next_s.ph = PH_WAIT; // not ours: no ack
                next_s.sda_rel = 1'b1;
              end
            end else begin
              if (s.pos != POS_LAST) begin
                next_s.pos = s.pos + 3'h1;
              end
              // fields after the code byte are frozen while an access is running
              case (rx_fld)
                POS_CODE: begin
                  next_s.block = s.sh[CODE_BLOCK_BIT];
                  next_s.code_ok = (s.sh[2:0] == CODE_FUNC_EEPROM);
                  next_s.armed = 1'b0;
                end
                POS_CTRL: begin
                  if (!s.busy) begin
                    next_s.op = s.sh[0];
                    next_s.use_given_address = s.sh[1];
                  end
                end
                POS_EEPROM_BUS_ADDRESS: begin
                  if (!s.busy) begin
                    next_s.eeprom_bus_address = s.sh;
                  end
                end
                POS_OFFL: begin
                  if (!s.busy) begin
                    next_s.offset[7:0] = s.sh;
                  end
                end
                POS_OFFH: begin
                  if (!s.busy) begin
                    next_s.offset[15:8] = s.sh;
                  end
                  next_s.armed = s.code_ok & s.op;
                end
                POS_DATA: begin
                  if (!s.busy) begin
                    next_s.wdata = s.sh;
                  end
                  next_s.armed = s.code_ok & ~s.op;
                end
                default: begin
                end
              endcase
            end
          end
        end
        PH_ACK: begin
          if (scl_fall) begin
            next_s.sda_rel = 1'b1;
            next_s.bitcnt = 4'h0;
            next_s.addr_byte = 1'b0;
            next_s.ph = PH_RX;
            if (s.addr_byte && s.rd_xfer) begin
              // first response byte goes out on this same fall
              next_s.sh = {tx_byte[6:0], 1'b0};
              next_s.sda_rel = tx_byte[7];
              next_s.bitcnt = 4'h1;
              next_s.txi = s.txi + 3'h1;
              next_s.ph = PH_TX;
              if (tx_fld == POS_COUNT) begin
                next_s.flags = 3'h0;
              end
            end
          end
        end
        PH_TX: begin
          if (scl_fall) begin
            if (s.bitcnt < 4'h8) begin
              next_s.sda_rel = s.sh[7];
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.bitcnt = s.bitcnt + 4'h1;
            end else begin
              next_s.sda_rel = 1'b1;
              next_s.ph = PH_ACKIN;
            end
          end
        end
        PH_ACKIN: begin
          if (scl_rise) begin
            if (sda) begin
              next_s.ph = PH_WAIT; // host nack ends the response
            end else begin
              next_s.sh = tx_byte;
              next_s.bitcnt = 4'h0;
              next_s.txi = s.txi + 3'h1;
              next_s.ph = PH_TX;
              if (tx_fld == POS_COUNT) begin
                // clear-on-read of the error flags
                next_s.flags = 3'h0;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    // set wins over the clear of the same cycle
    if (ee_done && s.busy) begin
      next_s.flags = next_s.flags |
        {ee_framing_err, ee_arb_err, ee_nack_err};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ph <= PH_IDLE;
      s.scl_sync <= 2'b11;
      s.sda_sync <= 2'b11;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.sda_rel <= 1'b1;
      s.rdata <= BYTE_RST;
    end else begin
      s <= next_s;
    end
  end

  // the device never drives the clock; sda only pulls low
  assign link.dev_scl_o = 1'b0;
  assign link.dev_scl_oe_n = 1'b1;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = s.sda_rel;
  assign ee_req = s.req;
  assign ee_read = s.op;
  assign ee_bus_address = s.bus_addr;
  assign ee_offset = s.offset;
  assign ee_wdata = s.wdata;
endmodule

// File: core/sme_host.sv
// Purpose: smbus host controller issuing eeprom access commands
// Assumes: single master on the link, slave never stretches scl
// Notes: scl comes from a divider; a read waits a fixed gap
`timescale 1ns/1ps
module sme_host
  import sme_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC,
  parameter int GAP = GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic irq,
  sme_link_if.host link
);
  import sme_pkg::*;

  typedef struct packed {
    logic [1:0] sda_sync;
    logic busy;
    logic op;
    logic use_given_address;
    logic block;
    logic [15:0] offset;
    logic [6:0] eeprom_bus_address;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] status;
    logic nack;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [4:0] step;
    logic [3:0] bitn;
    logic [1:0] q;
    logic [15:0] qcnt;
    logic [7:0] sh;
    logic scl_rel;
    logic sda_rel;
    logic ack;
    logic [31:0] dat_r;
  } sme_host_state_type;

  sme_host_state_type s;
  sme_host_state_type next_s;
  sme_sym_type sym;
  logic [7:0] byt;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic tick;

  assign tick = (s.qcnt == 16'(QUARTER - 1));

  // exchange script: setup or write part, then after a setup the returning read
  always_comb begin
    sym = SYM_SKIP;
    byt = 8'h00;
    case (s.step)
      5'd0, 5'd10: sym = SYM_START;
      5'd1, 5'd11: begin sym = SYM_WR; byt = {SLAVE_ADDR, 1'b0}; end
      5'd2, 5'd12: begin
        sym = SYM_WR;
        byt = {4'h0, s.block, CODE_FUNC_EEPROM};
      end
      5'd3: if (s.block) begin
        sym = SYM_WR;
        byt = s.op ? COUNT_SETUP : COUNT_WRITE;
      end
      5'd4: begin
        sym = SYM_WR;
        byt = sme_ctrl_byte(s.op, s.use_given_address, 3'h0);
      end
      5'd5: begin sym = SYM_WR; byt = {s.eeprom_bus_address, 1'b0}; end
      5'd6: begin sym = SYM_WR; byt = s.offset[7:0]; end
      5'd7: begin sym = SYM_WR; byt = s.offset[15:8]; end
      5'd8: if (!s.op) begin sym = SYM_WR; byt = s.wdata; end
      5'd9, 5'd18: sym = SYM_STOP;
      5'd13: sym = SYM_START;
      5'd14: begin sym = SYM_WR; byt = {SLAVE_ADDR, 1'b1}; end
      5'd15: if (s.block) sym = SYM_RD_ACK;
      5'd16: sym = SYM_RD_ACK;
      5'd17: sym = SYM_RD_NACK;
      5'd19: sym = SYM_END;
      5'd31: sym = SYM_WAIT;
      default: sym = SYM_SKIP;
    endcase
  end

  // register read image
  always_comb begin
    case (wb_adr)
      REG_CTRL: rd_word = {23'h0, s.busy, 4'h0, s.block, s.use_given_address, s.op, 1'b0};
      REG_OFFSET: rd_word = {16'h0, s.offset};
      REG_WDATA: rd_word = {17'h0, s.eeprom_bus_address, s.wdata};
      REG_RESULT: rd_word = {15'h0, s.nack, s.status, s.rdata};
      REG_IRQ_ST: rd_word = {30'h0, s.irq_st};
      REG_IRQ_MASK: rd_word = {30'h0, s.irq_mask};
      default: rd_word = 32'h0;
    endcase
    wr_word = sme_merge(rd_word, wb_dat_w, wb_sel);
  end

  always_comb begin
    next_s = s;
    next_s.sda_sync = {s.sda_sync[0], link.sda_i};
    // bus slave: ack one cycle after the request, write at ack edge
    next_s.ack = wb_cyc & wb_stb & ~s.ack;
    if (wb_cyc && wb_stb && !s.ack) begin
      next_s.dat_r = rd_word;
    end
    if (wb_cyc && wb_stb && wb_we && s.ack) begin
      case (wb_adr)
        REG_CTRL: begin
          if (!s.busy) begin
            next_s.op = wr_word[1];
            next_s.use_given_address = wr_word[2];
            next_s.block = wr_word[3];
            if (wr_word[0]) begin
              next_s.busy = 1'b1;
              next_s.step = 5'd0;
              next_s.bitn = 4'h0;
              next_s.q = 2'h0;
              next_s.qcnt = 16'h0;
              next_s.nack = 1'b0;
            end
          end
        end
        REG_OFFSET: next_s.offset = wr_word[15:0];
        REG_WDATA: begin
          next_s.wdata = wr_word[7:0];
          next_s.eeprom_bus_address = wr_word[14:8];
        end
        REG_IRQ_ST: next_s.irq_st = s.irq_st & ~wr_word[1:0];
        REG_IRQ_MASK: next_s.irq_mask = wr_word[1:0];
        default: begin
        end
      endcase
    end
    // symbol engine, four quarters per bit
    if (s.busy) begin
      next_s.qcnt = tick ? 16'h0 : s.qcnt + 16'h1;
      if (sym == SYM_SKIP) begin
        next_s.qcnt = 16'h0;
        next_s.step = (s.step == 5'd9 && s.op) ? 5'd31 :
                      (s.step == 5'd9) ? 5'd19 : s.step + 5'd1;
      end else if (sym == SYM_END) begin
        next_s.busy = 1'b0;
        next_s.irq_st[0] = 1'b1;
        next_s.irq_st[1] = next_s.irq_st[1] | s.nack;
      end else if (sym == SYM_WAIT) begin
        // leave the device time for its eeprom access
        next_s.qcnt = s.qcnt + 16'h1;
        if (s.qcnt == 16'(GAP - 1)) begin
          next_s.qcnt = 16'h0;
          next_s.step = 5'd10;
        end
      end else if (tick) begin
        next_s.q = s.q + 2'h1;
        if (sym == SYM_START || sym == SYM_STOP) begin
          case (s.q)
            2'h0: next_s.sda_rel = (sym == SYM_START);
            2'h1: next_s.scl_rel = 1'b1;
            2'h2: next_s.sda_rel = (sym == SYM_STOP);
            default: begin
              next_s.scl_rel = (sym == SYM_STOP);
              // after the first stop: a read waits, a write ends
              if (s.step == 5'd9) begin
                next_s.step = s.op ? 5'd31 : 5'd19;
              end else begin
                next_s.step = s.step + 5'd1;
              end
            end
          endcase
        end else begin
          case (s.q)
            2'h0: begin
              if (s.bitn == 4'h0) begin
                next_s.sh = byt;
              end
              if (s.bitn == 4'h8) begin
                next_s.sda_rel = (sym != SYM_RD_ACK);
              end else if (sym == SYM_WR) begin
                next_s.sda_rel = (s.bitn == 4'h0) ? byt[7] : s.sh[7];
              end else begin
                next_s.sda_rel = 1'b1;
              end
            end
            2'h1: next_s.scl_rel = 1'b1;
            2'h2: begin
              if (s.bitn != 4'h8) begin
                next_s.sh = {s.sh[6:0], s.sda_sync[1]};
              end else if (sym == SYM_WR && s.sda_sync[1]) begin
                next_s.nack = 1'b1;
              end
            end
            default: begin
              next_s.scl_rel = 1'b0;
              next_s.bitn = s.bitn + 4'h1;
              if (s.bitn == 4'h8) begin
                next_s.bitn = 4'h0;
                next_s.step = s.step + 5'd1;
                if (s.step == 5'd16) next_s.status = s.sh;
                if (s.step == 5'd17) next_s.rdata = s.sh;
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.sda_sync <= 2'b11;
      s.scl_rel <= 1'b1;
      s.sda_rel <= 1'b1;
      s.irq_st <= IRQ_RST;
      s.irq_mask <= IRQ_RST;
    end else begin
      s <= next_s;
    end
  end

  // the host drives every byte except the returned ones
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = s.scl_rel;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = s.sda_rel;
  assign wb_dat_r = s.dat_r;
  assign wb_ack = s.ack;
  assign irq = |(s.irq_st & s.irq_mask);
endmodule

// File: tb/sme_link_monitor.sv
// Purpose: checks on the open-drain link between host and decoder
// Assumes: one quarter of a bit is QUARTER system clocks
// Notes: sees only the interface wires and enables
`timescale 1ns/1ps
module sme_link_monitor #(
  parameter int QUARTER = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic scl_i,
  input wire logic sda_i
);
  localparam int SPAN = 8 * QUARTER;
  localparam int LIM = 40 * QUARTER;
  logic [15:0] pull_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // length of one device pull; a stuck ack would outlast any byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pull_cnt <= 16'h0000;
    end else begin
      pull_cnt <= dev_sda_oe_n ? 16'h0000 : pull_cnt + 16'h0001;
    end
  end
  property p_dev_no_scl; dev_scl_oe_n; endproperty
  a_dev_no_scl: assert property (p_dev_no_scl)
    else $error("device drove scl");
  property p_dev_low; !dev_sda_oe_n |-> !dev_sda_o; endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device drove sda high");
  // device may only move sda once scl has been low through the sync
  property p_dev_edge;
    $changed(dev_sda_oe_n) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("device moved sda with scl high");
  property p_dev_len; pull_cnt < LIM; endproperty
  a_dev_len: assert property (p_dev_len)
    else $error("device held sda too long");
  property p_scl_high; $rose(host_scl_oe_n) |-> host_scl_oe_n[*8];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase too short");
  property p_scl_low; $fell(host_scl_oe_n) |-> !host_scl_oe_n[*8];
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl low phase too short");
  property p_start;
    $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:SPAN] !scl_i;
  endproperty
  a_start: assert property (p_start)
    else $error("no clocking after start");
  property p_stop;
    $rose(sda_i) && scl_i && $past(scl_i) |-> (scl_i && sda_i)[*4];
  endproperty
  a_stop: assert property (p_stop)
    else $error("bus not idle after stop");
  property p_rel;
    $fell(rst) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n;
  endproperty
  a_rel: assert property (p_rel)
    else $error("wire pulled at reset release");
endmodule

// File: tb/tb_smbus_slave_eeprom_access.sv
// Purpose: drives host over wishbone, plays the eeprom engine
// Assumes: short quarter and gap; engine answers inside the gap
// Notes: random fields from a fixed seed plus a few corner values
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_smbus_slave_eeprom_access;
  import sme_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc, wb_stb, wb_we, wb_ack, irq, ee_req, ee_read, ee_done;
  logic [7:0] wb_adr, ee_wdata, ee_rdata, wd, rdat;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  logic [6:0] ee_bus_address, adr7;
  logic [6:0] dflt = 7'h33;
  logic [15:0] ee_offset, off;
  logic [2:0] err_v, nerr, acc;
  logic rd, use_a, blk;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  sme_link_if sme_link_if_i ();
  sme_host #(.QUARTER(8), .GAP(64)) sme_host_i (.sys_clk(sys_clk),
    .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .irq(irq),
    .link(sme_link_if_i));
  sme_dev sme_dev_i (.sys_clk(sys_clk), .rst(rst),
    .link(sme_link_if_i), .ee_req(ee_req), .ee_read(ee_read),
    .ee_bus_address(ee_bus_address), .ee_offset(ee_offset),
    .ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata),
    .ee_nack_err(err_v[0]), .ee_arb_err(err_v[1]),
    .ee_framing_err(err_v[2]), .default_master_address(dflt));
  sme_link_monitor #(.QUARTER(8)) sme_link_monitor_i (
    .sys_clk(sys_clk), .rst(rst),
    .host_scl_oe_n(sme_link_if_i.host_scl_oe_n),
    .host_sda_oe_n(sme_link_if_i.host_sda_oe_n),
    .dev_scl_oe_n(sme_link_if_i.dev_scl_oe_n),
    .dev_sda_oe_n(sme_link_if_i.dev_sda_oe_n),
    .dev_sda_o(sme_link_if_i.dev_sda_o),
    .scl_i(sme_link_if_i.scl_i), .sda_i(sme_link_if_i.sda_i));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one classic cycle; held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (wb_ack === 1'b1) break;
    end
    if (k == 50) begin
      bad_count++;
      end_of_test;
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // engine stand-in: checks the request, answers after a random delay
  initial begin
    forever begin
      @(posedge sys_clk);
      if (ee_req === 1'b1) begin
        `CHK("ee_read", rd, ee_read)
        `CHK("ee_addr", use_a ? adr7 : dflt, ee_bus_address)
        `CHK("ee_offset", off, ee_offset)
        if (!rd) `CHK("ee_wdata", wd, ee_wdata)
        repeat (1 + $urandom % 20) @(posedge sys_clk);
        ee_done <= 1'b1;
        ee_rdata <= rdat;
        err_v <= nerr;
        acc = acc | nerr;
        @(posedge sys_clk);
        ee_done <= 1'b0;
      end
    end
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, ee_done} = 4'h0;
    {wb_adr, ee_rdata, wb_dat_w} = 48'h0;
    wb_sel = 4'hf;
    err_v = 3'h0;
    acc = 3'h0;
    q = $urandom(31);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd = i[0];
      blk = (i < 2) || ($urandom % 2);
      use_a = $urandom % 2;
      adr7 = 7'($urandom);
      off = (i == 2) ? 16'hffff : 16'($urandom);
      wd = 8'($urandom);
      rdat = (i == 3) ? 8'h00 : 8'($urandom);
      nerr = (i == 2) ? 3'h7 : 3'($urandom);
      wb(1'b1, REG_IRQ_MASK, {31'h0, i != 7});
      wb(1'b1, REG_OFFSET, {16'h0, off});
      wb(1'b1, REG_WDATA, {17'h0, adr7, wd});
      wb(1'b1, REG_CTRL, {28'h0, blk, use_a, rd, 1'b1});
      wb(1'b0, REG_CTRL, 32'h0);
      `CHK("busy", 1'b1, q[8])
      for (n = 0; n < 6000; n++) begin
        wb(1'b0, REG_CTRL, 32'h0);
        if (q[8] !== 1'b1) break;
      end
      if (n == 6000) begin
        bad_count++;
        end_of_test;
      end
      `CHK("irq", i != 7, irq)
      if (rd) begin
        wb(1'b0, REG_RESULT, 32'h0);
        `CHK("result", {18'h0, acc, 1'b0, use_a, 1'b1, rdat}, q)
        acc = 3'h0;
      end
      wb(1'b0, REG_IRQ_ST, 32'h0);
      `CHK("irq_st", 32'h1, q)
      wb(1'b1, REG_IRQ_ST, 32'h1);
      wb(1'b0, REG_IRQ_ST, 32'h0);
      `CHK("irq_clr", 32'h0, q)
      $display("test %0d done", i);
    end
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    end_of_test;
  end
endmodule
